// >>> verilog/lbm_decoder.v
// Purpose: decode and execute logic, boolean and byte move opcodes
// Assumes: sequencer fetches operands named by the decode outputs
// Notes:   decode answers one cycle after opcode_valid, execution
//          one cycle after exe_start; both are registered
`timescale 1ns/1ps
`include "lbm_defines.vh"

module lbm_decoder (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst_n,
    // Opcode from fetch
    input  wire [7:0] opcode,
    input  wire       opcode_valid,
    // Operands from sequencer
    input  wire       exe_start,
    input  wire [7:0] exe_dst_val,
    input  wire [7:0] exe_src_val,
    input  wire       carry_in,
    input  wire       bit_in,
    // Decode results
    output reg        dec_ready,
    output reg        dec_known,
    output reg  [1:0] dec_len,
    output reg  [1:0] dec_cycles,
    output reg  [3:0] dec_op,
    output reg  [2:0] dec_src,
    output reg  [2:0] dec_dst,
    output reg  [2:0] dec_reg_idx,
    // Execution results
    output reg        exe_done,
    output reg  [7:0] exe_result,
    output reg        exe_carry,
    output reg        exe_bit,
    output reg        exe_wr_byte,
    output reg        exe_wr_carry,
    output reg        exe_wr_bit
);

    // ****************************************
    // Decode table
    // ****************************************
    reg       next_known;
    reg [1:0] next_len;
    reg [1:0] next_cycles;
    reg [3:0] next_op;
    reg [2:0] next_src;
    reg [2:0] next_dst;
    reg [2:0] next_reg_idx;

    task put;
        input [1:0] len;
        input [1:0] cyc;
        input [3:0] op;
        input [2:0] src;
        input [2:0] dst;
        begin
            next_known  = 1'b1;
            next_len    = len;
            next_cycles = cyc;
            next_op     = op;
            next_src    = src;
            next_dst    = dst;
        end
    endtask

    always @* begin
        next_known   = 1'b0;
        next_len     = `LBM_N1;
        next_cycles  = `LBM_N1;
        next_op      = `LBM_OP_NONE;
        next_src     = `LBM_LOC_NONE;
        next_dst     = `LBM_LOC_NONE;
        // Bank index in low three bits, pointer select in bit 0
        next_reg_idx = opcode[2:0];
        casez (opcode)
            `LBM_AND_BANK: put(`LBM_N1, `LBM_N1, `LBM_OP_AND,
                               `LBM_LOC_BANK, `LBM_LOC_ACC);
            `LBM_AND_DIR: put(`LBM_N2, `LBM_N2, `LBM_OP_AND,
                              `LBM_LOC_DIR, `LBM_LOC_ACC);
            `LBM_AND_IND: put(`LBM_N1, `LBM_N1, `LBM_OP_AND,
                              `LBM_LOC_IND, `LBM_LOC_ACC);
            `LBM_AND_IMM: put(`LBM_N2, `LBM_N2, `LBM_OP_AND,
                              `LBM_LOC_IMM, `LBM_LOC_ACC);
            `LBM_AND_TODIR: put(`LBM_N2, `LBM_N2, `LBM_OP_AND,
                                `LBM_LOC_ACC, `LBM_LOC_DIR);
            `LBM_AND_DIMM: put(`LBM_N3, `LBM_N3, `LBM_OP_AND,
                               `LBM_LOC_IMM, `LBM_LOC_DIR);
            `LBM_OR_BANK: put(`LBM_N1, `LBM_N1, `LBM_OP_OR,
                              `LBM_LOC_BANK, `LBM_LOC_ACC);
            `LBM_OR_DIR: put(`LBM_N2, `LBM_N2, `LBM_OP_OR,
                             `LBM_LOC_DIR, `LBM_LOC_ACC);
            `LBM_OR_IND: put(`LBM_N1, `LBM_N1, `LBM_OP_OR,
                             `LBM_LOC_IND, `LBM_LOC_ACC);
            `LBM_OR_IMM: put(`LBM_N2, `LBM_N2, `LBM_OP_OR,
                             `LBM_LOC_IMM, `LBM_LOC_ACC);
            `LBM_OR_TODIR: put(`LBM_N2, `LBM_N2, `LBM_OP_OR,
                               `LBM_LOC_ACC, `LBM_LOC_DIR);
            `LBM_OR_DIMM: put(`LBM_N3, `LBM_N3, `LBM_OP_OR,
                              `LBM_LOC_IMM, `LBM_LOC_DIR);
            `LBM_XOR_BANK: put(`LBM_N1, `LBM_N1, `LBM_OP_XOR,
                               `LBM_LOC_BANK, `LBM_LOC_ACC);
            `LBM_XOR_DIR: put(`LBM_N2, `LBM_N2, `LBM_OP_XOR,
                              `LBM_LOC_DIR, `LBM_LOC_ACC);
            `LBM_XOR_IND: put(`LBM_N1, `LBM_N1, `LBM_OP_XOR,
                              `LBM_LOC_IND, `LBM_LOC_ACC);
            `LBM_XOR_IMM: put(`LBM_N2, `LBM_N2, `LBM_OP_XOR,
                              `LBM_LOC_IMM, `LBM_LOC_ACC);
            `LBM_XOR_TODIR: put(`LBM_N2, `LBM_N2, `LBM_OP_XOR,
                                `LBM_LOC_ACC, `LBM_LOC_DIR);
            `LBM_XOR_DIMM: put(`LBM_N3, `LBM_N3, `LBM_OP_XOR,
                               `LBM_LOC_IMM, `LBM_LOC_DIR);
            `LBM_CLR_A: put(`LBM_N1, `LBM_N1, `LBM_OP_CLR,
                            `LBM_LOC_ACC, `LBM_LOC_ACC);
            `LBM_CPL_A: put(`LBM_N1, `LBM_N1, `LBM_OP_CPL,
                            `LBM_LOC_ACC, `LBM_LOC_ACC);
            `LBM_SWAP_A: put(`LBM_N1, `LBM_N1, `LBM_OP_SWAP,
                             `LBM_LOC_ACC, `LBM_LOC_ACC);
            `LBM_RL_A: put(`LBM_N1, `LBM_N1, `LBM_OP_RL,
                           `LBM_LOC_ACC, `LBM_LOC_ACC);
            `LBM_RCL_A: put(`LBM_N1, `LBM_N1, `LBM_OP_RCL,
                            `LBM_LOC_ACC, `LBM_LOC_ACC);
            `LBM_RR_A: put(`LBM_N1, `LBM_N1, `LBM_OP_RR,
                           `LBM_LOC_ACC, `LBM_LOC_ACC);
            `LBM_RCR_A: put(`LBM_N1, `LBM_N1, `LBM_OP_RCR,
                            `LBM_LOC_ACC, `LBM_LOC_ACC);
            `LBM_CLR_C: put(`LBM_N1, `LBM_N1, `LBM_OP_CLR,
                            `LBM_LOC_NONE, `LBM_LOC_CARRY);
            `LBM_CLR_BIT: put(`LBM_N2, `LBM_N2, `LBM_OP_CLR,
                              `LBM_LOC_NONE, `LBM_LOC_BIT);
            `LBM_SETB_C: put(`LBM_N1, `LBM_N1, `LBM_OP_SETB,
                             `LBM_LOC_NONE, `LBM_LOC_CARRY);
            `LBM_SETB_BIT: put(`LBM_N2, `LBM_N2, `LBM_OP_SETB,
                               `LBM_LOC_NONE, `LBM_LOC_BIT);
            `LBM_CPL_C: put(`LBM_N1, `LBM_N1, `LBM_OP_CPL,
                            `LBM_LOC_NONE, `LBM_LOC_CARRY);
            `LBM_CPL_BIT: put(`LBM_N2, `LBM_N2, `LBM_OP_CPL,
                              `LBM_LOC_NONE, `LBM_LOC_BIT);
            `LBM_AND_CBIT: put(`LBM_N2, `LBM_N2, `LBM_OP_AND,
                               `LBM_LOC_BIT, `LBM_LOC_CARRY);
            `LBM_ANDN_CBIT: put(`LBM_N2, `LBM_N2, `LBM_OP_ANDN,
                                `LBM_LOC_BIT, `LBM_LOC_CARRY);
            `LBM_OR_CBIT: put(`LBM_N2, `LBM_N2, `LBM_OP_OR,
                              `LBM_LOC_BIT, `LBM_LOC_CARRY);
            `LBM_ORN_CBIT: put(`LBM_N2, `LBM_N2, `LBM_OP_ORN,
                               `LBM_LOC_BIT, `LBM_LOC_CARRY);
            `LBM_XFR_CBIT: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                               `LBM_LOC_BIT, `LBM_LOC_CARRY);
            `LBM_XFR_BITC: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                               `LBM_LOC_CARRY, `LBM_LOC_BIT);
            `LBM_XFR_A_BNK: put(`LBM_N1, `LBM_N1, `LBM_OP_MOVE,
                                `LBM_LOC_BANK, `LBM_LOC_ACC);
            `LBM_XFR_A_DIR: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                                `LBM_LOC_DIR, `LBM_LOC_ACC);
            `LBM_XFR_A_IND: put(`LBM_N1, `LBM_N1, `LBM_OP_MOVE,
                                `LBM_LOC_IND, `LBM_LOC_ACC);
            `LBM_XFR_A_IMM: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                                `LBM_LOC_IMM, `LBM_LOC_ACC);
            `LBM_XFR_BNK_A: put(`LBM_N1, `LBM_N1, `LBM_OP_MOVE,
                                `LBM_LOC_ACC, `LBM_LOC_BANK);
            `LBM_XFR_BNK_D: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                                `LBM_LOC_DIR, `LBM_LOC_BANK);
            `LBM_XFR_BNK_I: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                                `LBM_LOC_IMM, `LBM_LOC_BANK);
            `LBM_XFR_D_A: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                              `LBM_LOC_ACC, `LBM_LOC_DIR);
            `LBM_XFR_D_BNK: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                                `LBM_LOC_BANK, `LBM_LOC_DIR);
            `LBM_XFR_D_D: put(`LBM_N3, `LBM_N3, `LBM_OP_MOVE,
                              `LBM_LOC_DIR, `LBM_LOC_DIR);
            `LBM_XFR_D_IND: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                                `LBM_LOC_IND, `LBM_LOC_DIR);
            `LBM_XFR_D_IMM: put(`LBM_N3, `LBM_N3, `LBM_OP_MOVE,
                                `LBM_LOC_IMM, `LBM_LOC_DIR);
            `LBM_XFR_IND_A: put(`LBM_N1, `LBM_N1, `LBM_OP_MOVE,
                                `LBM_LOC_ACC, `LBM_LOC_IND);
            `LBM_XFR_IND_D: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                                `LBM_LOC_DIR, `LBM_LOC_IND);
            `LBM_XFR_IND_I: put(`LBM_N2, `LBM_N2, `LBM_OP_MOVE,
                                `LBM_LOC_IMM, `LBM_LOC_IND);
            default: begin
                // Opcodes outside this block report length zero
                next_len    = `LBM_N0;
                next_cycles = `LBM_N0;
            end
        endcase
    end

    // ****************************************
    // Decode registers
    // ****************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_ready   <= 1'b0;
            dec_known   <= 1'b0;
            dec_len     <= `LBM_N0;
            dec_cycles  <= `LBM_N0;
            dec_op      <= `LBM_OP_NONE;
            dec_src     <= `LBM_LOC_NONE;
            dec_dst     <= `LBM_LOC_NONE;
            dec_reg_idx <= 3'h0;
        end else begin
            dec_ready <= opcode_valid;
            if (opcode_valid) begin
                dec_known   <= next_known;
                dec_len     <= next_len;
                dec_cycles  <= next_cycles;
                dec_op      <= next_op;
                dec_src     <= next_src;
                dec_dst     <= next_dst;
                dec_reg_idx <= next_reg_idx;
            end
        end
    end

    // ****************************************
    // Execution
    // ****************************************
    reg [7:0] next_result;
    reg       next_carry;
    reg       next_bit;
    reg       bit_x;
    reg       bit_y;
    reg       bit_r;
    wire      dst_carry = (dec_dst == `LBM_LOC_CARRY);
    wire      dst_bit   = (dec_dst == `LBM_LOC_BIT);
    wire      dst_byte  = dec_known && !dst_carry && !dst_bit;

    always @* begin
        next_result = exe_dst_val;
        next_carry  = carry_in;
        bit_x       = dst_carry ? carry_in : bit_in;
        bit_y       = (dec_src == `LBM_LOC_CARRY) ? carry_in : bit_in;
        bit_r       = bit_x;
        // Byte path: destination value combined with source
        case (dec_op)
            `LBM_OP_AND:  next_result = exe_dst_val & exe_src_val;
            `LBM_OP_OR:   next_result = exe_dst_val | exe_src_val;
            `LBM_OP_XOR:  next_result = exe_dst_val ^ exe_src_val;
            `LBM_OP_MOVE: next_result = exe_src_val;
            `LBM_OP_RCL: begin
                next_result = {exe_dst_val[6:0], carry_in};
                next_carry  = exe_dst_val[7];
            end
            `LBM_OP_RCR: begin
                next_result = {carry_in, exe_dst_val[7:1]};
                next_carry  = exe_dst_val[0];
            end
            `LBM_OP_RL:   next_result = {exe_dst_val[6:0], exe_dst_val[7]};
            `LBM_OP_RR:   next_result = {exe_dst_val[0], exe_dst_val[7:1]};
            `LBM_OP_CLR:  next_result = 8'h00;
            `LBM_OP_CPL:  next_result = ~exe_dst_val;
            `LBM_OP_SWAP: next_result = {exe_dst_val[3:0], exe_dst_val[7:4]};
            default:      next_result = exe_dst_val;
        endcase
        // Bit path: carry or addressed bit as destination
        case (dec_op)
            `LBM_OP_AND:  bit_r = bit_x & bit_y;
            `LBM_OP_ANDN: bit_r = bit_x & ~bit_y;
            `LBM_OP_OR:   bit_r = bit_x | bit_y;
            `LBM_OP_ORN:  bit_r = bit_x | ~bit_y;
            `LBM_OP_MOVE: bit_r = bit_y;
            `LBM_OP_CLR:  bit_r = 1'b0;
            `LBM_OP_CPL:  bit_r = ~bit_x;
            `LBM_OP_SETB: bit_r = 1'b1;
            default:      bit_r = bit_x;
        endcase
        if (dst_carry) begin
            next_carry = bit_r;
        end
        next_bit = dst_bit ? bit_r : bit_in;
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            exe_done     <= 1'b0;
            exe_result   <= 8'h00;
            exe_carry    <= 1'b0;
            exe_bit      <= 1'b0;
            exe_wr_byte  <= 1'b0;
            exe_wr_carry <= 1'b0;
            exe_wr_bit   <= 1'b0;
        end else begin
            exe_done     <= exe_start;
            exe_wr_byte  <= exe_start && dst_byte;
            // Only rotates through carry and carry targets touch carry
            exe_wr_carry <= exe_start && dec_known &&
                            (dst_carry || dec_op == `LBM_OP_RCL ||
                             dec_op == `LBM_OP_RCR);
            // Source bit is left alone for the inverted carry forms
            exe_wr_bit   <= exe_start && dec_known && dst_bit;
            if (exe_start) begin
                exe_result <= next_result;
                exe_carry  <= next_carry;
                exe_bit    <= next_bit;
            end
        end
    end

endmodule

// >>> verilog/lbm_defines.vh
// Purpose: constants for the logic, boolean and move opcode decoder
// Assumes: opcodes arrive as whole bytes from the core fetch logic
// Notes:   patterns with ? are matched with casez
//
// How it works
// - 55 ANDs direct byte into accumulator
// - 56-57 AND pointed byte into accumulator
// - 52 ANDs accumulator into direct byte
// - 53 ANDs immediate into direct byte
// - 68-6F XOR bank register into accumulator
// - 66-67 XOR pointed byte into accumulator
// - 64 XORs immediate into accumulator
// - 62 XORs accumulator into direct byte
// - 63 XORs immediate into direct byte
// - 33 rotates accumulator left through carry
// - 13 rotates accumulator right through carry
// - 82 ANDs direct bit into carry
// - 72 ORs direct bit into carry
// - A0 ORs inverted bit into carry
// - A2 bit to carry, 92 carry to bit
// - 85 copies direct byte to direct byte
// - 75 writes immediate into direct byte
// - 88-8F copy bank register to direct
// - A8-AF load bank register from direct
// - 86-87 copy pointed byte to direct
// - A6-A7 store direct byte at pointer
// - 78-7F load immediate into bank register
// - Effects match the standard core exactly
`ifndef LBM_DEFINES_VH
`define LBM_DEFINES_VH

// ****************************************
// Operation codes
// ****************************************
`define LBM_OP_NONE   4'h0
`define LBM_OP_AND    4'h1
`define LBM_OP_OR     4'h2
`define LBM_OP_XOR    4'h3
`define LBM_OP_MOVE   4'h4
`define LBM_OP_RCL    4'h5
`define LBM_OP_RCR    4'h6
`define LBM_OP_RL     4'h7
`define LBM_OP_RR     4'h8
`define LBM_OP_CLR    4'h9
`define LBM_OP_CPL    4'hA
`define LBM_OP_SWAP   4'hB
`define LBM_OP_ANDN   4'hC
`define LBM_OP_ORN    4'hD
`define LBM_OP_SETB   4'hE

// ****************************************
// Operand locations
// ****************************************
`define LBM_LOC_NONE  3'h0
`define LBM_LOC_ACC   3'h1
`define LBM_LOC_BANK  3'h2
`define LBM_LOC_DIR   3'h3
`define LBM_LOC_IND   3'h4
`define LBM_LOC_IMM   3'h5
`define LBM_LOC_CARRY 3'h6
`define LBM_LOC_BIT   3'h7

// ****************************************
// Lengths and cycle counts
// ****************************************
`define LBM_N0        2'h0
`define LBM_N1        2'h1
`define LBM_N2        2'h2
`define LBM_N3        2'h3

// ****************************************
// Opcode patterns
// ****************************************
`define LBM_AND_BANK  8'b0101_1???
`define LBM_AND_DIR   8'h55
`define LBM_AND_IND   8'b0101_011?
`define LBM_AND_IMM   8'h54
`define LBM_AND_TODIR 8'h52
`define LBM_AND_DIMM  8'h53
`define LBM_OR_BANK   8'b0100_1???
`define LBM_OR_DIR    8'h45
`define LBM_OR_IND    8'b0100_011?
`define LBM_OR_IMM    8'h44
`define LBM_OR_TODIR  8'h42
`define LBM_OR_DIMM   8'h43
`define LBM_XOR_BANK  8'b0110_1???
`define LBM_XOR_DIR   8'h65
`define LBM_XOR_IND   8'b0110_011?
`define LBM_XOR_IMM   8'h64
`define LBM_XOR_TODIR 8'h62
`define LBM_XOR_DIMM  8'h63
`define LBM_CLR_A     8'hE4
`define LBM_CPL_A     8'hF4
`define LBM_SWAP_A    8'hC4
`define LBM_RL_A      8'h23
`define LBM_RCL_A     8'h33
`define LBM_RR_A      8'h03
`define LBM_RCR_A     8'h13
`define LBM_CLR_C     8'hC3
`define LBM_CLR_BIT   8'hC2
`define LBM_SETB_C    8'hD3
`define LBM_SETB_BIT  8'hD2
`define LBM_CPL_C     8'hB3
`define LBM_CPL_BIT   8'hB2
`define LBM_AND_CBIT  8'h82
`define LBM_ANDN_CBIT 8'hB0
`define LBM_OR_CBIT   8'h72
`define LBM_ORN_CBIT  8'hA0
`define LBM_XFR_CBIT  8'hA2
`define LBM_XFR_BITC  8'h92
`define LBM_XFR_A_BNK 8'b1110_1???
`define LBM_XFR_A_DIR 8'hE5
`define LBM_XFR_A_IND 8'b1110_011?
`define LBM_XFR_A_IMM 8'h74
`define LBM_XFR_BNK_A 8'b1111_1???
`define LBM_XFR_BNK_D 8'b1010_1???
`define LBM_XFR_BNK_I 8'b0111_1???
`define LBM_XFR_D_A   8'hF5
`define LBM_XFR_D_BNK 8'b1000_1???
`define LBM_XFR_D_D   8'h85
`define LBM_XFR_D_IND 8'b1000_011?
`define LBM_XFR_D_IMM 8'h75
`define LBM_XFR_IND_A 8'b1111_011?
`define LBM_XFR_IND_D 8'b1010_011?
`define LBM_XFR_IND_I 8'b0111_011?

`endif

// >>> bench/lbm_decoder_props.sv
// Purpose: port-level assertions for the opcode decoder
// Assumes: one clock, rst_n asynchronous and active low
// Notes:   bound into every lbm_decoder instance
`timescale 1ns/1ps
module lbm_decoder_chk (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // Stimulus side
    input wire logic [7:0] opcode,
    input wire logic       opcode_valid,
    input wire logic       exe_start,
    input wire logic [7:0] exe_dst_val,
    input wire logic [7:0] exe_src_val,
    input wire logic       carry_in,
    input wire logic       bit_in,
    // Decode results
    input wire logic       dec_ready,
    input wire logic       dec_known,
    input wire logic [1:0] dec_len,
    input wire logic [1:0] dec_cycles,
    input wire logic [3:0] dec_op,
    input wire logic [2:0] dec_src,
    input wire logic [2:0] dec_dst,
    input wire logic [2:0] dec_reg_idx,
    // Execution results
    input wire logic       exe_done,
    input wire logic [7:0] exe_result,
    input wire logic       exe_carry,
    input wire logic       exe_bit,
    input wire logic       exe_wr_byte,
    input wire logic       exe_wr_carry,
    input wire logic       exe_wr_bit
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // Decode then execute, no new decode between
    // ****************************************
    sequence s_dec(op);
        opcode_valid && opcode == op;
    endsequence
    sequence s_run(op);
        s_dec(op) ##1 (exe_start && !opcode_valid);
    endsequence

    AST_DEC_READY: assert property (opcode_valid |=> dec_ready)
        else $error("decode answer missing");
    AST_DEC_QUIET: assert property (!opcode_valid |=> !dec_ready)
        else $error("decode answer without request");
    AST_EXE_DONE: assert property (exe_start |=> exe_done)
        else $error("execute answer missing");
    AST_EXE_CAUSE: assert property ($rose(exe_done) |-> $past(exe_start))
        else $error("execute answer without request");
    AST_LEN_EQ: assert property (dec_ready |-> dec_len == dec_cycles)
        else $error("length and cycle count differ");
    AST_LEN3: assert property (opcode_valid &&
        opcode inside {8'h53, 8'h63, 8'h85, 8'h75}
        |=> dec_known && dec_len == 2'h3 && dec_cycles == 2'h3)
        else $error("three byte opcode decoded wrongly");
    AST_XOR_BANK: assert property (opcode_valid &&
        opcode[7:3] == 5'h0D |=> dec_len == 2'h1 && dec_cycles == 2'h1)
        else $error("bank exclusive-or length wrong");
    AST_RCL: assert property (s_run(8'h33) |=> exe_wr_byte &&
        exe_result == {$past(exe_dst_val[6:0]), $past(carry_in)} &&
        exe_carry == $past(exe_dst_val[7]))
        else $error("left rotate through carry wrong");
    AST_RCR: assert property (s_run(8'h13) |=> exe_wr_carry &&
        exe_result == {$past(carry_in), $past(exe_dst_val[7:1])} &&
        exe_carry == $past(exe_dst_val[0]))
        else $error("right rotate through carry wrong");
    AST_ORN: assert property (s_run(8'hA0) |=> exe_wr_carry &&
        !exe_wr_byte && !exe_wr_bit &&
        exe_carry == ($past(carry_in) | ~$past(bit_in)))
        else $error("or with inverted bit wrong");
    AST_XFRBC: assert property (s_run(8'h92) |=> exe_wr_bit &&
        !exe_wr_carry && exe_bit == $past(carry_in))
        else $error("carry to bit move wrong");
    AST_BIT_ROUTE: assert property (opcode_valid &&
        opcode == 8'h92 |=> dec_src == 3'h6 && dec_dst == 3'h7)
        else $error("carry to bit operands decoded wrongly");
    AST_UNK: assert property (exe_done && !dec_known && !dec_ready
        |-> !exe_wr_byte && !exe_wr_carry && !exe_wr_bit)
        else $error("write pulse for foreign opcode");
endmodule

bind lbm_decoder lbm_decoder_chk u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .opcode(opcode),
    .opcode_valid(opcode_valid), .exe_start(exe_start),
    .exe_dst_val(exe_dst_val), .exe_src_val(exe_src_val),
    .carry_in(carry_in), .bit_in(bit_in), .dec_ready(dec_ready),
    .dec_known(dec_known), .dec_len(dec_len), .dec_cycles(dec_cycles),
    .dec_op(dec_op), .dec_src(dec_src), .dec_dst(dec_dst),
    .dec_reg_idx(dec_reg_idx), .exe_done(exe_done),
    .exe_result(exe_result), .exe_carry(exe_carry), .exe_bit(exe_bit),
    .exe_wr_byte(exe_wr_byte), .exe_wr_carry(exe_wr_carry),
    .exe_wr_bit(exe_wr_bit)
);

// >>> bench/lbm_tb.sv
// Purpose: self-checking bench for the opcode decoder
// Assumes: fixed one-cycle decode and execute latencies
// Notes:   operands random from a fixed seed
`timescale 1ns/1ps
module tb;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic       opcode_valid = 1'b0;
    logic       exe_start = 1'b0;
    logic [7:0] exe_dst_val = 8'h00;
    logic [7:0] exe_src_val = 8'h00;
    logic       carry_in = 1'b0;
    logic       bit_in = 1'b0;
    logic       dec_ready, dec_known, exe_done, exe_carry, exe_bit;
    logic       exe_wr_byte, exe_wr_carry, exe_wr_bit;
    logic [1:0] dec_len, dec_cycles;
    logic [3:0] dec_op;
    logic [2:0] dec_src, dec_dst, dec_reg_idx;
    logic [7:0] exe_result;
    int         err_total = 0;
    int         comparisons = 0;
    logic [7:0] pool [0:5] = '{8'h55, 8'h33, 8'h13, 8'h92, 8'hA0, 8'h85};

    lbm_decoder dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .opcode(opcode),
        .opcode_valid(opcode_valid), .exe_start(exe_start),
        .exe_dst_val(exe_dst_val), .exe_src_val(exe_src_val),
        .carry_in(carry_in), .bit_in(bit_in), .dec_ready(dec_ready),
        .dec_known(dec_known), .dec_len(dec_len), .dec_cycles(dec_cycles),
        .dec_op(dec_op), .dec_src(dec_src), .dec_dst(dec_dst),
        .dec_reg_idx(dec_reg_idx), .exe_done(exe_done),
        .exe_result(exe_result), .exe_carry(exe_carry), .exe_bit(exe_bit),
        .exe_wr_byte(exe_wr_byte), .exe_wr_carry(exe_wr_carry),
        .exe_wr_bit(exe_wr_bit)
    );

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Expectations
    // ****************************************
    // Packed {length, cycles}; zero for foreign opcodes A5 and 84, others default to 2/2
    function automatic logic [3:0] exp_lc(input logic [7:0] op);
        casez (op)
            8'h53, 8'h63, 8'h85, 8'h75: exp_lc = 4'hF;
            8'b0101_011?, 8'b0110_1???, 8'b0110_011?: exp_lc = 4'h5;
            8'h33, 8'h13: exp_lc = 4'h5;
            8'hA5, 8'h84: exp_lc = 4'h0;
            default: exp_lc = 4'hA;
        endcase
    endfunction

    // Packed {op, wr_byte, wr_carry, wr_bit, carry, bit, result}
    function automatic logic [16:0] exp_exe(input logic [7:0] op, d, s,
                                            input logic c, b);
        logic [7:0] r;
        logic [3:0] o;
        logic       wb, wc, wt, nc, nb;
        r = s;
        o = 4'h4;
        wb = 1'b1;
        wc = 1'b0;
        wt = 1'b0;
        nc = c;
        nb = b;
        casez (op)
            8'h5?: {o, r} = {4'h1, d & s};
            8'h6?: {o, r} = {4'h3, d ^ s};
            8'h33: {nc, r, wc, o} = {d, c, 5'h15};
            8'h13: {r, nc, wc, o} = {c, d, 5'h16};
            8'h82: {o, wb, wc, nc} = {6'h05, c & b};
            8'h72: {o, wb, wc, nc} = {6'h09, c | b};
            8'hA0: {o, wb, wc, nc} = {6'h35, c | ~b};
            8'hA2: {wb, wc, nc} = {2'h1, b};
            8'h92: {wb, wt, nb} = {2'h1, c};
            8'hA5, 8'h84: {o, wb} = 5'h00;
            default: r = s;
        endcase
        exp_exe = {o, wb, wc, wt, nc, nb, r};
    endfunction

    // ****************************************
    // Checking and transfers
    // ****************************************
    task automatic chk(input string name, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic run_op(input logic [7:0] op);
        logic [7:0]  d;
        logic [7:0]  s;
        logic        c;
        logic        b;
        logic [3:0]  lc;
        logic [16:0] e;
        d = 8'($urandom);
        s = 8'($urandom);
        c = 1'($urandom);
        b = 1'($urandom);
        lc = exp_lc(op);
        e = exp_exe(op, d, s, c, b);
        @(posedge sys_clk);
        opcode <= op;
        opcode_valid <= 1'b1;
        @(posedge sys_clk);
        opcode_valid <= 1'b0;
        exe_start <= 1'b1;
        {exe_dst_val, exe_src_val, carry_in, bit_in} <= {d, s, c, b};
        #1;
        chk("dec_ready", 8'(dec_ready), 8'h01);
        chk("dec_len", 8'(dec_len), 8'(lc[3:2]));
        chk("dec_cycles", 8'(dec_cycles), 8'(lc[1:0]));
        chk("dec_known", 8'(dec_known), 8'(lc != 4'h0));
        chk("dec_op", 8'(dec_op), 8'(e[16:13]));
        chk("dec_reg_idx", 8'(dec_reg_idx), 8'(op[2:0]));
        @(posedge sys_clk);
        exe_start <= 1'b0;
        #1;
        chk("dec_ready_low", 8'(dec_ready), 8'h00);
        chk("exe_done", 8'(exe_done), 8'h01);
        chk("exe_wr", 8'({exe_wr_byte, exe_wr_carry, exe_wr_bit}),
            8'(e[12:10]));
        chk("exe_carry", 8'(exe_carry), 8'(e[9]));
        if (e[12]) chk("exe_result", exe_result, e[7:0]);
        if (e[10]) chk("exe_bit", 8'(exe_bit), 8'(e[8]));
        $display("test opcode %h done", op);
    endtask

    task automatic run_rng(input logic [7:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            run_op(base + 8'(i));
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h9972));
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        run_op(8'h55);
        run_rng(8'h56, 2);
        run_op(8'h52);
        run_op(8'h53);
        run_rng(8'h68, 8);
        run_rng(8'h66, 2);
        run_op(8'h64);
        run_op(8'h62);
        run_op(8'h63);
        run_op(8'h33);
        run_op(8'h13);
        run_op(8'h82);
        run_op(8'h72);
        run_op(8'hA0);
        run_op(8'hA2);
        run_op(8'h92);
        run_op(8'h85);
        run_op(8'h75);
        run_rng(8'h88, 8);
        run_rng(8'hA8, 8);
        run_rng(8'h86, 2);
        run_rng(8'hA6, 2);
        run_rng(8'h78, 8);
        run_op(8'hA5);
        run_op(8'h84);
        repeat (30) run_op(pool[$urandom_range(5)]);
        // Back-to-back decode with the strobe held
        @(posedge sys_clk);
        {opcode, opcode_valid} <= {8'h53, 1'b1};
        @(posedge sys_clk);
        opcode <= 8'h13;
        #1;
        chk("dec_len_b2b", 8'(dec_len), 8'h03);
        @(posedge sys_clk);
        opcode_valid <= 1'b0;
        #1;
        chk("dec_len_b2b", 8'(dec_len), 8'h01);
        chk("dec_ready_b2b", 8'(dec_ready), 8'h01);
        // Reset in mid-run clears the held decode
        @(posedge sys_clk);
        rst_n <= 1'b0;
        #1;
        chk("dec_len_rst", 8'(dec_len), 8'h00);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        run_op(8'h33);
        $display("test reset and back-to-back done");
        end_sim();
    end
endmodule
